//--- hdl/tfa_params.svh
// Constants for the timer fault input and wide register access block.
`ifndef TFA_PARAMS_SVH
`define TFA_PARAMS_SVH
`define TFA_ADDR_W        6
`define TFA_ADDR_CTRL_A   6'h30
`define TFA_ADDR_CTRL_D   6'h26
`define TFA_ADDR_HIGH     6'h25
`define TFA_ADDR_COUNT    6'h2E
`define TFA_ADDR_CMP_A    6'h2D
`define TFA_ADDR_CMP_B    6'h2C
`define TFA_ADDR_CMP_C    6'h2B
`define TFA_ADDR_CMP_D    6'h2A
`define TFA_CTRL_A_RST    8'h00
`define TFA_CTRL_D_RST    8'h00
`define TFA_CTRL_A_RDMASK 8'hF3
`define TFA_FLAG_BIT      2
`define TFA_FILT_TAPS     4
`endif

//--- hdl/tfa_pkg.sv
// Types shared by the timer fault input and wide register access block.
package tfa_pkg;
   typedef struct packed {
      logic [1:0] out_mode_a;
      logic [1:0] out_mode_b;
      logic       force_match_a;
      logic       force_match_b;
      logic       pwm_en_a;
      logic       pwm_en_b;
   } tfa_ctrl_a_t;
   typedef struct packed {
      logic fault_irq_enable;
      logic fault_enable;
      logic fault_noise_filter_en;
      logic fault_edge_rise;
      logic fault_src_select;
      logic fault_flag;
      logic [1:0] spare;
   } tfa_ctrl_d_t;
   typedef struct packed {
      logic       addr_unused;
      logic [5:0] addr;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } tfa_bus_t;
   typedef logic [9:0] tfa_word_t;
   typedef tfa_word_t [3:0] tfa_cmp_t;
endpackage

//--- hdl/tfa_top.sv
// Fault trigger input path and ten-bit register access for the PWM timer.
`timescale 1ns/1ns
`include "tfa_params.svh"
module tfa_top (
   // Clock, reset and enable.
   input  wire  logic                ref_clk,
   input  wire  logic                resetn,
   input  wire  logic                clk_en,
   // Processor I/O bus.
   input  wire  tfa_pkg::tfa_bus_t   io_bus,
   output logic [7:0]                io_rdata,
   // Fault inputs.
   input  wire  logic                fault_ext_pin,
   input  wire  logic                comparator_out,
   input  wire  logic                port_drive_en,
   input  wire  logic                port_out,
   // Timer side.
   input  wire  tfa_pkg::tfa_word_t  count_live,
   output logic                      count_load,
   output tfa_pkg::tfa_word_t        count_load_val,
   output tfa_pkg::tfa_cmp_t         compare_values,
   output tfa_pkg::tfa_ctrl_a_t      timer_ctrl_a,
   output tfa_pkg::tfa_ctrl_d_t      timer_ctrl_d,
   output logic                      fault_irq
);
   import tfa_pkg::*;

   // ************************************************************
   // Input sampling, noise filter and edge detector.
   // ************************************************************
   logic [2:0] pin_sh;
   logic [2:0] cmp_sh;
   logic       pin_val;
   logic       cmp_val;
   logic [2:0] hist;
   logic       filt;
   logic       det_prev;
   logic [2:0] next_pin_sh;
   logic [2:0] next_cmp_sh;
   logic       next_pin_val;
   logic       next_cmp_val;
   logic [2:0] next_hist;
   logic       next_filt;
   logic       next_det_prev;
   logic       src_raw;
   logic [3:0] window;
   logic       det_in;
   logic       hit;

   always_comb begin
      next_pin_sh = {pin_sh[1:0], fault_ext_pin};
      next_cmp_sh = {cmp_sh[1:0], comparator_out};
      // A change counts once the second and third stages agree.
      next_pin_val = (pin_sh[2] == pin_sh[1]) ? pin_sh[2] : pin_val;
      next_cmp_val = (cmp_sh[2] == cmp_sh[1]) ? cmp_sh[2] : cmp_val;
      // The port output bit already lives on this clock, so it skips the sampler.
      if (timer_ctrl_d.fault_src_select) begin
         src_raw = cmp_val;
      end else if (port_drive_en) begin
         src_raw = port_out;
      end else begin
         src_raw = pin_val;
      end
      window = {hist, src_raw};
      next_hist = window[2:0];
      if (window == 4'hF) begin
         next_filt = 1'b1;
      end else if (window == 4'h0) begin
         next_filt = 1'b0;
      end else begin
         next_filt = filt;
      end
      det_in = timer_ctrl_d.fault_noise_filter_en ? filt : src_raw;
      next_det_prev = det_in;
      hit = timer_ctrl_d.fault_edge_rise ? (det_in & ~det_prev)
                                         : (~det_in & det_prev);
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pin_sh   <= 3'h0;
         cmp_sh   <= 3'h0;
         pin_val  <= 1'b0;
         cmp_val  <= 1'b0;
         hist     <= 3'h0;
         filt     <= 1'b0;
         det_prev <= 1'b0;
      end else if (clk_en) begin
         pin_sh   <= next_pin_sh;
         cmp_sh   <= next_cmp_sh;
         pin_val  <= next_pin_val;
         cmp_val  <= next_cmp_val;
         hist     <= next_hist;
         filt     <= next_filt;
         det_prev <= next_det_prev;
      end
   end

   // ************************************************************
   // Register file, ten-bit access and fault entry.
   // ************************************************************
   logic [1:0]  high;
   logic [1:0]  next_high;
   logic [7:0]  next_rdata;
   logic        next_count_load;
   tfa_word_t   next_count_val;
   tfa_cmp_t    next_cmp;
   tfa_ctrl_a_t next_ctrl_a;
   tfa_ctrl_d_t next_ctrl_d;
   logic        next_irq;
   logic        wr;
   logic        rd;
   logic        cmp_hit;
   logic [1:0]  cmp_idx;

   // Maps a compare low-byte address to its index.
   function automatic logic [2:0] cmp_decode(input logic [5:0] a);
      unique case (a)
         `TFA_ADDR_CMP_A: cmp_decode = 3'h4;
         `TFA_ADDR_CMP_B: cmp_decode = 3'h5;
         `TFA_ADDR_CMP_C: cmp_decode = 3'h6;
         `TFA_ADDR_CMP_D: cmp_decode = 3'h7;
         default:         cmp_decode = 3'h0;
      endcase
   endfunction

   always_comb begin
      wr = io_bus.wr;
      rd = io_bus.rd;
      {cmp_hit, cmp_idx} = cmp_decode(io_bus.addr);
      next_high = high;
      next_rdata = 8'h00;
      next_count_load = 1'b0;
      next_count_val = count_load_val;
      next_cmp = compare_values;
      next_ctrl_a = timer_ctrl_a;
      next_ctrl_a.force_match_a = 1'b0;
      next_ctrl_a.force_match_b = 1'b0;
      next_ctrl_d = timer_ctrl_d;
      next_irq = 1'b0;
      if (rd) begin
         if (io_bus.addr == `TFA_ADDR_CTRL_A) begin
            next_rdata = timer_ctrl_a & `TFA_CTRL_A_RDMASK;
         end else if (io_bus.addr == `TFA_ADDR_CTRL_D) begin
            next_rdata = timer_ctrl_d;
         end else if (io_bus.addr == `TFA_ADDR_HIGH) begin
            next_rdata = {6'h00, high};
         end else if (io_bus.addr == `TFA_ADDR_COUNT) begin
            next_rdata = count_live[7:0];
            next_high = count_live[9:8];
         end else if (cmp_hit) begin
            next_rdata = compare_values[cmp_idx][7:0];
            next_high = compare_values[cmp_idx][9:8];
         end
      end
      if (wr) begin
         if (io_bus.addr == `TFA_ADDR_CTRL_A) begin
            next_ctrl_a = io_bus.wdata;
         end else if (io_bus.addr == `TFA_ADDR_CTRL_D) begin
            next_ctrl_d = io_bus.wdata;
            next_ctrl_d.fault_flag = timer_ctrl_d.fault_flag
                                     & ~io_bus.wdata[`TFA_FLAG_BIT];
            next_ctrl_d.spare = 2'h0;
         end else if (io_bus.addr == `TFA_ADDR_HIGH) begin
            next_high = io_bus.wdata[1:0];
         end else if (io_bus.addr == `TFA_ADDR_COUNT) begin
            next_count_load = 1'b1;
            next_count_val = {high, io_bus.wdata};
         end else if (cmp_hit) begin
            next_cmp[cmp_idx] = {high, io_bus.wdata};
         end
      end
      // A detected edge sets the flag even during a clearing write.
      if (hit) begin
         next_ctrl_d.fault_flag = 1'b1;
      end
      if (hit && timer_ctrl_d.fault_enable) begin
         next_ctrl_a.out_mode_a = 2'h0;
         next_ctrl_a.out_mode_b = 2'h0;
         next_ctrl_d.fault_enable = 1'b0;
         next_irq = timer_ctrl_d.fault_irq_enable;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         high           <= 2'h0;
         io_rdata       <= 8'h00;
         count_load     <= 1'b0;
         count_load_val <= 10'h000;
         compare_values <= '0;
         timer_ctrl_a   <= `TFA_CTRL_A_RST;
         timer_ctrl_d   <= `TFA_CTRL_D_RST;
         fault_irq      <= 1'b0;
      end else if (clk_en) begin
         high           <= next_high;
         io_rdata       <= next_rdata;
         count_load     <= next_count_load;
         count_load_val <= next_count_val;
         compare_values <= next_cmp;
         timer_ctrl_a   <= next_ctrl_a;
         timer_ctrl_d   <= next_ctrl_d;
         fault_irq      <= next_irq;
      end
   end

   // ************************************************************
   // Assertions and covers.
   // ************************************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   // Flops move only while clk_en is high, so every antecedent carries it.

   // Input path.
   a_pin_source: assert property (clk_en
      && !timer_ctrl_d.fault_src_select && !port_drive_en
      && !timer_ctrl_d.fault_noise_filter_en |=> det_prev == $past(pin_val))
      else $error("pin source not used");
   a_src_comparator: assert property (clk_en && timer_ctrl_d.fault_src_select
      && !timer_ctrl_d.fault_noise_filter_en |=> det_prev == $past(cmp_val))
      else $error("comparator source not used");
   a_sync_agree: assert property (clk_en && pin_sh[2] != pin_sh[1]
      |=> $stable(pin_val))
      else $error("pin sample moved without agreement");
   a_port_drive: assert property (clk_en && !timer_ctrl_d.fault_src_select
      && port_drive_en && !timer_ctrl_d.fault_noise_filter_en
      |=> det_prev == $past(port_out))
      else $error("port output not seen by fault path");
   a_filter_hold: assert property (clk_en && window != 4'hF && window != 4'h0
      |=> $stable(filt))
      else $error("filter moved without four equal samples");
   a_filter_set: assert property (clk_en && window == 4'hF |=> filt)
      else $error("filter missed four high samples");
   a_filter_bypass: assert property (clk_en
      && !timer_ctrl_d.fault_noise_filter_en |=> det_prev == $past(src_raw))
      else $error("filter not bypassed");
   a_filter_delay: assert property (clk_en && $changed(src_raw)
      ##1 (clk_en && $stable(src_raw)) [*3] |=> filt == $past(src_raw))
      else $error("filter latency not four cycles");
   a_filter_sample: assert property (clk_en |=> hist[0] == $past(src_raw))
      else $error("filter missed a sample");

   // Register access.
   a_high_read: assert property (clk_en && rd && io_bus.addr == `TFA_ADDR_HIGH
      |=> io_rdata == {6'h00, $past(high)})
      else $error("high byte read wrong");
   a_high_write: assert property (clk_en && wr && !rd
      && io_bus.addr == `TFA_ADDR_HIGH |=> high == $past(io_bus.wdata[1:0]))
      else $error("high byte write wrong");
   a_low_write: assert property (clk_en && wr && io_bus.addr == `TFA_ADDR_CMP_A
      |=> compare_values[0] == {$past(high), $past(io_bus.wdata)})
      else $error("compare low write wrong");
   a_low_write_d: assert property (clk_en && wr && io_bus.addr == `TFA_ADDR_CMP_D
      |=> compare_values[3] == {$past(high), $past(io_bus.wdata)})
      else $error("last compare low write wrong");
   a_count_write: assert property (clk_en && wr && io_bus.addr == `TFA_ADDR_COUNT
      |=> count_load && count_load_val == {$past(high), $past(io_bus.wdata)})
      else $error("count low write wrong");
   a_low_read: assert property (clk_en && rd && !wr
      && io_bus.addr == `TFA_ADDR_COUNT |=> high == $past(count_live[9:8]))
      else $error("high bits not staged on read");
   a_cmp_read: assert property (clk_en && rd && !wr
      && io_bus.addr == `TFA_ADDR_CMP_A |=> high == $past(compare_values[0][9:8]))
      else $error("compare high bits not staged");
   a_high_keep: assert property (clk_en && wr && !rd && cmp_hit |=> $stable(high))
      else $error("high byte lost after low write");
   a_ctrl_a_write: assert property (clk_en && wr && !hit
      && io_bus.addr == `TFA_ADDR_CTRL_A
      |=> timer_ctrl_a.out_mode_a == $past(io_bus.wdata[7:6]))
      else $error("control A write wrong");
   a_ctrl_a_readback: assert property (clk_en && rd
      && io_bus.addr == `TFA_ADDR_CTRL_A |=> io_rdata[3:2] == 2'h0)
      else $error("force bits read back");
   a_force_pulse: assert property (clk_en
      && !(wr && io_bus.addr == `TFA_ADDR_CTRL_A)
      |=> !timer_ctrl_a.force_match_a && !timer_ctrl_a.force_match_b)
      else $error("force bit held");

   // Fault entry and flag.
   a_fault_entry: assert property (clk_en && hit && timer_ctrl_d.fault_enable
      |=> timer_ctrl_a.out_mode_a == 2'h0 && timer_ctrl_a.out_mode_b == 2'h0
      && !timer_ctrl_d.fault_enable)
      else $error("fault entry incomplete");
   a_fault_irq: assert property (clk_en && hit && timer_ctrl_d.fault_enable
      && timer_ctrl_d.fault_irq_enable |=> fault_irq)
      else $error("fault interrupt missing");
   a_irq_quiet: assert property (clk_en && !(hit && timer_ctrl_d.fault_enable
      && timer_ctrl_d.fault_irq_enable) |=> !fault_irq)
      else $error("stray fault interrupt");
   a_flag_set: assert property (clk_en && hit |=> timer_ctrl_d.fault_flag)
      else $error("fault flag not set");
   a_flag_clear: assert property (clk_en && !hit && wr
      && io_bus.addr == `TFA_ADDR_CTRL_D && io_bus.wdata[`TFA_FLAG_BIT]
      |=> !timer_ctrl_d.fault_flag)
      else $error("fault flag not cleared");
   a_flag_hold: assert property (clk_en && !hit
      && !(wr && io_bus.addr == `TFA_ADDR_CTRL_D) |=> $stable(timer_ctrl_d.fault_flag))
      else $error("fault flag moved by itself");

   // Main scenarios.
   c_fault_entry: cover property (clk_en && hit && timer_ctrl_d.fault_enable);
   c_filtered_hit: cover property (clk_en && hit && timer_ctrl_d.fault_noise_filter_en);
   c_falling_hit: cover property (clk_en && hit && !timer_ctrl_d.fault_edge_rise);
   c_wide_write: cover property (wr && io_bus.addr == `TFA_ADDR_HIGH
      ##[1:4] wr && io_bus.addr == `TFA_ADDR_COUNT);
   c_wide_read: cover property (rd && cmp_hit
      ##[1:4] rd && io_bus.addr == `TFA_ADDR_HIGH);
endmodule // tfa_top

//--- tb/tfa_cpu_model.sv
// Processor core model that drives the timer's byte-wide I/O bus.
`timescale 1ns/1ns
`include "tfa_params.svh"
module tfa_cpu_model (
   // Clock.
   input  wire logic           ref_clk,
   // Bus toward the timer.
   output tfa_pkg::tfa_bus_t   io_bus
);
   import tfa_pkg::*;
   initial io_bus = '0;
   // ****************************************
   // Bus cycles
   // ****************************************
   // One strobe cycle; idle lines then carry inverted values so nothing stale looks valid.
   task automatic access(input logic [5:0] a, input logic [7:0] d, input logic w);
      @(posedge ref_clk);
      io_bus <= '{1'b0, a, w, !w, d};
      @(posedge ref_clk);
      io_bus <= '{1'b1, ~a, 1'b0, 1'b0, ~d};
      #1;
   endtask
   // The staging byte goes out before the low byte, with nothing in between.
   task automatic wide_wr(input logic [5:0] a, input logic [9:0] v);
      access(`TFA_ADDR_HIGH, {6'h00, v[9:8]}, 1'b1);
      access(a, v[7:0], 1'b1);
   endtask
endmodule // tfa_cpu_model

//--- tb/tfa_top_tb_top.sv
// Self-checking bench for the timer fault input and wide register access block.
`timescale 1ns/1ns
`include "tfa_params.svh"
module tfa_top_tb_top;
   import tfa_pkg::*;
   logic          ref_clk = 0, resetn = 0, clk_en = 1, fault_irq, count_load;
   logic          fault_ext_pin = 0, comparator_out = 0, port_drive_en = 0, port_out = 0;
   logic          rd_prev = 0, ld_prev = 0;
   logic [1:0]    frc_prev = 2'h0;
   logic [7:0]    io_rdata;
   logic [7:0]    exp_q[$];
   logic [15:0]   rnd = 16'h782B;
   tfa_word_t     count_live = '0, count_load_val;
   tfa_bus_t      io_bus;
   tfa_cmp_t      compare_values;
   tfa_ctrl_a_t   timer_ctrl_a;
   tfa_ctrl_d_t   timer_ctrl_d;
   int            bad_count = 0, n_checks = 0, cycles = 0, irq_count = 0;
   int            lat_raw, lat_filt, lat;
   always #10 ref_clk = ~ref_clk;
   tfa_cpu_model cpu (.ref_clk(ref_clk), .io_bus(io_bus));
   tfa_top uut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .io_bus(io_bus),
      .io_rdata(io_rdata), .fault_ext_pin(fault_ext_pin), .comparator_out(comparator_out),
      .port_drive_en(port_drive_en), .port_out(port_out), .count_live(count_live),
      .count_load(count_load), .count_load_val(count_load_val),
      .compare_values(compare_values), .timer_ctrl_a(timer_ctrl_a),
      .timer_ctrl_d(timer_ctrl_d), .fault_irq(fault_irq));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic check(input string nm, input logic [9:0] e, input logic [9:0] s);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wrap_up();
      if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      cpu.access(a, d, 1'b1);
   endtask
   task automatic rd(input logic [5:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      cpu.access(a, 8'h00, 1'b0);
   endtask
   // Arms the fault path from one source, raises it and checks the protection entry.
   task automatic fault_run(input logic [7:0] cfg, input int sel, output int lat);
      int irq_base;
      wr(`TFA_ADDR_CTRL_A, 8'hF3);
      wr(`TFA_ADDR_CTRL_D, cfg);
      check("flag_clear", 0, timer_ctrl_d.fault_flag);
      @(posedge ref_clk);
      port_drive_en <= (sel == 2);
      irq_base = irq_count;
      repeat (8) @(posedge ref_clk);
      case (sel)
         0: fault_ext_pin <= 1'b1;
         1: comparator_out <= 1'b1;
         default: port_out <= 1'b1;
      endcase
      lat = 0;
      while (timer_ctrl_d.fault_flag !== 1'b1 && lat < 20) begin
         @(posedge ref_clk);
         #1;
         lat++;
      end
      repeat (2) @(posedge ref_clk);
      #1;
      check("fault_flag", 1, timer_ctrl_d.fault_flag);
      check("out_modes", cfg[6] ? 4'h0 : 4'hF, timer_ctrl_a[7:4]);
      check("fault_enable", 0, timer_ctrl_d.fault_enable);
      check("fault_irq", cfg[7] & cfg[6], 10'(irq_count - irq_base));
      @(posedge ref_clk);
      fault_ext_pin <= 1'b0;
      comparator_out <= 1'b0;
      port_out <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask
   // ****************************************
   // Output watcher
   // ****************************************
   always @(posedge ref_clk) begin
      if (resetn) begin
         if (rd_prev) check("io_rdata", exp_q.pop_front(), io_rdata);
         check("count_load", ld_prev, count_load);
         check("force_match", frc_prev, timer_ctrl_a[3:2]);
      end
      if (fault_irq === 1'b1) irq_count <= irq_count + 1;
      rd_prev <= resetn && clk_en && io_bus.rd;
      ld_prev <= resetn && clk_en && io_bus.wr && io_bus.addr == `TFA_ADDR_COUNT;
      frc_prev <= (resetn && clk_en && io_bus.wr && io_bus.addr == `TFA_ADDR_CTRL_A)
         ? io_bus.wdata[3:2] : 2'h0;
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         wrap_up();
      end
   end
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (2) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(`TFA_ADDR_CTRL_A, `TFA_CTRL_A_RST);
      rd(`TFA_ADDR_CTRL_D, `TFA_CTRL_D_RST);
      wr(`TFA_ADDR_CTRL_A, 8'hFF);
      rd(`TFA_ADDR_CTRL_A, `TFA_CTRL_A_RDMASK);
      wr(6'h3F, 8'h00);
      rd(6'h3F, 8'h00);
      @(posedge ref_clk);
      clk_en <= 1'b0;
      wr(`TFA_ADDR_CTRL_A, 8'h00);
      @(posedge ref_clk);
      clk_en <= 1'b1;
      rd(`TFA_ADDR_CTRL_A, 8'hF3);
      for (int i = 0; i < 5; i++) begin
         rnd = lfsr(rnd);
         cpu.wide_wr(`TFA_ADDR_COUNT - 6'(i), rnd[9:0]);
         if (i == 0) check("count_load_val", rnd[9:0], count_load_val);
         else check("compare_values", rnd[9:0], compare_values[i-1]);
      end
      wr(`TFA_ADDR_CMP_A, 8'h5A);
      check("cmp_a_reuse", {rnd[9:8], 8'h5A}, compare_values[0]);
      wr(`TFA_ADDR_HIGH, {6'h00, ~rnd[9:8]});
      rd(`TFA_ADDR_CMP_A, 8'h5A);
      rd(`TFA_ADDR_HIGH, {6'h00, rnd[9:8]});
      rnd = lfsr(rnd);
      @(posedge ref_clk);
      count_live <= rnd[9:0];
      rd(`TFA_ADDR_COUNT, rnd[7:0]);
      @(posedge ref_clk);
      count_live <= ~rnd[9:0];
      rd(`TFA_ADDR_HIGH, {6'h00, rnd[9:8]});
      fault_run(8'hD4, 0, lat_raw);
      fault_run(8'hF4, 0, lat_filt);
      check("filter_delay", 10'(lat_raw + `TFA_FILT_TAPS), 10'(lat_filt));
      fault_run(8'h5C, 1, lat);
      check("comparator_seen", 1, lat < 20);
      fault_run(8'h54, 2, lat);
      check("port_seen", 1, lat < 20);
      fault_run(8'h94, 0, lat);
      wr(`TFA_ADDR_CTRL_D, 8'h34);
      @(posedge ref_clk);
      fault_ext_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      fault_ext_pin <= 1'b0;
      repeat (12) @(posedge ref_clk);
      #1;
      check("glitch_flag", 0, timer_ctrl_d.fault_flag);
      wr(`TFA_ADDR_CTRL_D, 8'h44);
      @(posedge ref_clk);
      fault_ext_pin <= 1'b1;
      repeat (8) @(posedge ref_clk);
      #1;
      check("rise_ignored", 0, timer_ctrl_d.fault_flag);
      @(posedge ref_clk);
      fault_ext_pin <= 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      check("fall_flag", 1, timer_ctrl_d.fault_flag);
      check("fall_entry", 0, timer_ctrl_d.fault_enable);
      wrap_up();
   end
endmodule // tfa_top_tb_top
